// ### design/asfr_top.sv
// serial conversion and readout sequencer of a 10-bit sampling converter
//
// Summary of operation
// - a frame needs a chip select fall and then serial clocks, and advances only on that clock.
// - the input is tracked from the chip select fall up to the third serial clock falling edge.
// - from the third falling edge the sample is held and digitised for the rest of the frame.
// - on the sixteenth falling edge the data output goes high impedance and the frame ends.
// - a frame shifts out four zero bits, then the ten-bit result as straight binary, msb first.
// - the result shifted out belongs to the sample taken in the same frame, with no frame latency.
// - a chip select rise puts the device in automatic shutdown with its output high impedance.
// - after shutdown the next chip select fall with clocks gives a normal conversion and result.
`timescale 1ns/1ps

module asfr_top
  import asfr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [RESULT_BITS-1:0] sample_code,
  output logic serial_result_out,
  output logic serial_result_oe_n,
  output logic frame_active,
  output logic in_shutdown
);

  // ****************************************************************
  // state registers
  // ****************************************************************
  asfr_regs_type r_reg;
  asfr_regs_type r_next;
  logic cs_fall;
  logic cs_rise;
  logic sck_fall;
  logic [CNT_W-1:0] cnt_inc;

  // bit presented after a given number of falling edges
  function automatic logic bit_for(input logic [CNT_W-1:0] k,
                                   input logic [RESULT_BITS-1:0] h);
    logic [CNT_W-1:0] idx;
    idx = DATA_LAST_FALL - k;
    if (k >= DATA_FIRST_FALL && k <= DATA_LAST_FALL) begin
      return h[idx[3:0]];
    end
    return 1'b0;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    r_next = r_reg;
    // three-stage pin synchronisers; a level counts once stages two and three agree
    // a pin glitch shorter than one ref_clk cycle never reaches the edge detectors
    r_next.cs_sync = {r_reg.cs_sync[1:0], cs_n_pin};
    r_next.sck_sync = {r_reg.sck_sync[1:0], sclk_pin};
    if (r_reg.cs_sync[1] == r_reg.cs_sync[2]) begin
      r_next.cs_lvl = r_reg.cs_sync[2];
    end
    if (r_reg.sck_sync[1] == r_reg.sck_sync[2]) begin
      r_next.sck_lvl = r_reg.sck_sync[2];
    end
    cs_fall = r_reg.cs_lvl & ~r_next.cs_lvl;
    cs_rise = ~r_reg.cs_lvl & r_next.cs_lvl;
    sck_fall = r_reg.sck_lvl & ~r_next.sck_lvl;
    cnt_inc = r_reg.fall_cnt + 5'h01;

    case (r_reg.state)
      ST_SHUTDOWN: begin
        // clocks without a chip select fall are ignored here
        if (cs_fall) begin
          r_next.state = ST_SAMPLE;
          r_next.fall_cnt = CNT_RESET;
          r_next.sdo = 1'b0;
          r_next.sdo_oe_n = 1'b0;
        end
      end
      ST_SAMPLE, ST_CONVERT: begin
        if (cs_rise) begin
          // early deselect aborts the frame; the host loses that result
          r_next.state = ST_SHUTDOWN;
          r_next.sdo = 1'b0;
          r_next.sdo_oe_n = 1'b1;
        end else if (sck_fall) begin
          r_next.fall_cnt = cnt_inc;
          if (cnt_inc == SAMPLE_FALLS) begin
            // front end stops tracking: capture and hold
            r_next.hold = sample_code;
            r_next.state = ST_CONVERT;
          end
          if (cnt_inc == FRAME_FALLS) begin
            r_next.state = ST_DONE;
            r_next.sdo = 1'b0;
            r_next.sdo_oe_n = 1'b1;
          end else begin
            r_next.sdo = bit_for(cnt_inc, r_next.hold);
          end
        end
      end
      ST_DONE: begin
        // extra clocks after the sixteenth edge leave the output released
        if (cs_rise) begin
          r_next.state = ST_SHUTDOWN;
        end
      end
      default: begin
        r_next.state = ST_SHUTDOWN;
        r_next.sdo = 1'b0;
        r_next.sdo_oe_n = 1'b1;
      end
    endcase
    r_next.busy = (r_next.state == ST_SAMPLE) || (r_next.state == ST_CONVERT);
    r_next.shut = (r_next.state == ST_SHUTDOWN);
  end

  // ****************************************************************
  // register update
  // ****************************************************************
  // synchronous reset only, so the pins need no asynchronous path of their own
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r_reg <= REGS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs come straight from the state register
  assign serial_result_out = r_reg.sdo;
  assign serial_result_oe_n = r_reg.sdo_oe_n;
  assign frame_active = r_reg.busy;
  assign in_shutdown = r_reg.shut;

  // ****************************************************************
  // assertions
  // ****************************************************************
  // checks watch the filtered levels, so they see the same edges as the sequencer
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // expected data bit for the current count, helper for checks only
  logic exp_bit;
  assign exp_bit = bit_for(r_reg.fall_cnt, r_reg.hold);

  a_idle_no_start: assert property (
    (r_reg.state == ST_SHUTDOWN && !cs_fall) |=> (r_reg.state == ST_SHUTDOWN)
  ) else $error("sequencer left shutdown without a chip select fall");

  a_sample_capture: assert property (
    (r_reg.state == ST_SAMPLE && r_reg.fall_cnt == (SAMPLE_FALLS - 5'h01)
      && sck_fall && !cs_rise)
      |=> (r_reg.state == ST_CONVERT && r_reg.hold == $past(sample_code))
  ) else $error("sample not captured on third falling edge");

  a_hold_stable: assert property (
    (r_reg.state == ST_CONVERT) ##1 (r_reg.state == ST_CONVERT) |-> $stable(r_reg.hold)
  ) else $error("held sample changed during conversion");

  a_release_sixteenth: assert property (
    (r_reg.state == ST_CONVERT && r_reg.fall_cnt == (FRAME_FALLS - 5'h01)
      && sck_fall && !cs_rise)
      |=> (serial_result_oe_n && r_reg.state == ST_DONE && !frame_active)
  ) else $error("output not released on sixteenth falling edge");

  a_leading_zeros: assert property (
    (!serial_result_oe_n && r_reg.fall_cnt < LEAD_ZEROS) |-> !serial_result_out
  ) else $error("leading bit is not zero");

  a_result_bits: assert property (
    (!serial_result_oe_n && r_reg.fall_cnt >= DATA_FIRST_FALL)
      |-> (serial_result_out == exp_bit)
  ) else $error("result bit does not match held code");

  a_same_frame: assert property (
    (r_reg.state == ST_CONVERT && r_reg.fall_cnt == (DATA_FIRST_FALL - 5'h01)
      && sck_fall && !cs_rise)
      |=> (serial_result_out == r_reg.hold[RESULT_BITS-1] && $stable(r_reg.hold))
  ) else $error("first result bit is not this frame's msb");

  a_rise_shutdown: assert property (
    (cs_rise && r_reg.state != ST_SHUTDOWN)
      |=> (r_reg.state == ST_SHUTDOWN && serial_result_oe_n && in_shutdown)
  ) else $error("chip select rise did not enter shutdown");

  a_wake_frame: assert property (
    (r_reg.state == ST_SHUTDOWN && cs_fall)
      |=> (frame_active && !serial_result_oe_n && !serial_result_out
           && r_reg.fall_cnt == CNT_RESET)
  ) else $error("frame did not start after shutdown");

  a_idle_released: assert property (
    (r_reg.state == ST_SHUTDOWN || r_reg.state == ST_DONE) |-> serial_result_oe_n
  ) else $error("output driven outside a frame");

  a_count_steady: assert property (
    ((r_reg.state == ST_SAMPLE || r_reg.state == ST_CONVERT) && !sck_fall && !cs_rise)
      |=> $stable(r_reg.fall_cnt)
  ) else $error("fall counter moved without a serial clock fall");

  a_done_hold: assert property (
    (r_reg.state == ST_DONE && !cs_rise) |=> (r_reg.state == ST_DONE && serial_result_oe_n)
  ) else $error("extra clocks disturbed a finished frame");

  c_full_frame: cover property (
    (r_reg.state == ST_CONVERT) ##1 (r_reg.state == ST_DONE)
  );

  c_abort_frame: cover property (
    (r_reg.state == ST_SAMPLE) ##1 (r_reg.state == ST_SHUTDOWN)
  );

  c_msb_one: cover property (
    (r_reg.fall_cnt == DATA_FIRST_FALL && !serial_result_oe_n && serial_result_out)
  );

  c_extra_clocks: cover property (
    (r_reg.state == ST_DONE && sck_fall)
  );

endmodule

// ### design/asfr_pkg.sv
// constants, state codes and register layout for the serial frame readout sequencer
package asfr_pkg;

  // ****************************************************************
  // frame layout counted in serial clock falling edges
  // ****************************************************************
  localparam int unsigned RESULT_BITS = 10;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] SAMPLE_FALLS = 5'h03; // hold starts here
  localparam logic [CNT_W-1:0] LEAD_ZEROS = 5'h04; // zeros shifted ahead of the code
  localparam logic [CNT_W-1:0] DATA_FIRST_FALL = 5'h04;
  localparam logic [CNT_W-1:0] DATA_LAST_FALL = 5'h0d;
  localparam logic [CNT_W-1:0] FRAME_FALLS = 5'h10; // output released here
  localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;

  // ****************************************************************
  // pin synchroniser depth and idle levels
  // ****************************************************************
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [SYNC_STAGES-1:0] CS_SYNC_RESET = 3'h7; // deselected
  localparam logic [SYNC_STAGES-1:0] SCK_SYNC_RESET = 3'h0;
  localparam logic [RESULT_BITS-1:0] HOLD_RESET = 10'h000;

  // ****************************************************************
  // sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_SHUTDOWN = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_CONVERT = 4'h4,
    ST_DONE = 4'h8
  } asfr_state_type;

  // ****************************************************************
  // complete state of the sequencer
  // ****************************************************************
  typedef struct packed {
    logic [SYNC_STAGES-1:0] cs_sync;
    logic [SYNC_STAGES-1:0] sck_sync;
    logic cs_lvl;
    logic sck_lvl;
    asfr_state_type state;
    logic [CNT_W-1:0] fall_cnt;
    logic [RESULT_BITS-1:0] hold;
    logic sdo;
    logic sdo_oe_n;
    logic busy;
    logic shut;
  } asfr_regs_type;

  localparam asfr_regs_type REGS_RESET = '{
    cs_sync: CS_SYNC_RESET,
    sck_sync: SCK_SYNC_RESET,
    cs_lvl: 1'b1,
    sck_lvl: 1'b0,
    state: ST_SHUTDOWN,
    fall_cnt: CNT_RESET,
    hold: HOLD_RESET,
    sdo: 1'b0,
    sdo_oe_n: 1'b1,
    busy: 1'b0,
    shut: 1'b1
  };

endpackage

// ### test/asfr_host_model.sv
// host serial controller model: chip select, serial clock and bit capture
`timescale 1ns/1ps

module asfr_host_model
  import asfr_pkg::*;
(
  input wire logic ref_clk,
  output logic cs_n_pin,
  output logic sclk_pin,
  input wire logic serial_result_out,
  input wire logic serial_result_oe_n
);
  localparam int HALF = 16; // half of a 160 ns link period at 5 ns
  int falls = 0;
  logic [15:0] cap = 16'h0000;
  logic oe_end = 1'b1;

  // clock idles low and stands still between frames
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
  end

  // one frame: cs low, n pulses (stop after k falls when k > 0), cs high
  task automatic frame(input int n, input int k);
    falls = 0;
    @(negedge ref_clk) cs_n_pin = 1'b0;
    repeat (HALF) @(negedge ref_clk);
    for (int i = 0; i < n && !(k > 0 && falls == k); i++) begin
      sclk_pin = 1'b1;
      // a released output is taken as unknown so it never passes for data
      if (i < 16) cap = {cap[14:0], serial_result_oe_n ? 1'bx : serial_result_out};
      repeat (HALF) @(negedge ref_clk);
      sclk_pin = 1'b0;
      falls++;
      repeat (HALF) @(negedge ref_clk);
    end
    oe_end = serial_result_oe_n;
    cs_n_pin = 1'b1;
    repeat (HALF) @(negedge ref_clk);
  endtask
endmodule

// ### test/tb_adc_serial_frame_readout.sv
// self-checking testbench of the serial frame readout sequencer
`timescale 1ns/1ps

module tb_adc_serial_frame_readout;
  import asfr_pkg::*;

  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [RESULT_BITS-1:0] sample_code = 10'h000;
  logic cs_n_pin;
  logic sclk_pin;
  logic serial_result_out;
  logic serial_result_oe_n;
  logic frame_active;
  logic in_shutdown;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  // 200 MHz system clock
  always #2.5 ref_clk = ~ref_clk;

  asfr_top dut (.ref_clk(ref_clk), .srst(srst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .sample_code(sample_code), .serial_result_out(serial_result_out),
    .serial_result_oe_n(serial_result_oe_n), .frame_active(frame_active),
    .in_shutdown(in_shutdown));

  asfr_host_model host (.ref_clk(ref_clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n));

  // single comparison point, case equality so unknowns fail
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // input changes before the hold and after it; only the first may show
  task automatic code_frame(input logic [RESULT_BITS-1:0] code, input int n);
    fork
      host.frame(n, 0);
      begin
        wait (host.falls == 1);
        @(negedge ref_clk) sample_code = code;
        wait (host.falls == 4);
        @(negedge ref_clk) sample_code = ~code;
        check({14'h0, frame_active, in_shutdown}, 16'h0002, "mid frame");
      end
    join
    check(host.cap, {4'h0, code, 2'b00}, "frame bits");
    check({15'h0, host.oe_end}, 16'h0001, "release after last fall");
    check({14'h0, frame_active, in_shutdown}, 16'h0001, "idle after frame");
    $display("test frame %h with %0d clocks done", code, n);
  endtask

  // outputs stand released and idle right after reset
  task automatic reset_test();
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
    check({13'h0, serial_result_oe_n, frame_active, in_shutdown}, 16'h0005, "reset");
    $display("test reset done");
  endtask

  // first conversion after power-up is thrown away by the host
  task automatic discard_frame();
    host.frame(16, 0);
    check({15'h0, host.oe_end}, 16'h0001, "release after first frame");
    $display("test discarded frame done");
  endtask

  // chip select rise in mid frame drops straight to shutdown, in both phases
  task automatic abort_frame();
    host.frame(16, 8);
    check({15'h0, host.oe_end}, 16'h0000, "driving mid frame");
    check({13'h0, serial_result_oe_n, frame_active, in_shutdown}, 16'h0005, "abort");
    host.frame(16, 2);
    check({15'h0, host.oe_end}, 16'h0000, "driving while sampling");
    check({13'h0, serial_result_oe_n, frame_active, in_shutdown}, 16'h0005, "abort early");
    code_frame(10'h155, 16);
    $display("test abort done");
  endtask

  // hang guard, well above the roughly 4800 cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // main sequence
  initial begin
    reset_test();
    discard_frame();
    code_frame(10'h3ff, 16);
    code_frame(10'h200, 16);
    code_frame(10'h1ff, 16);
    code_frame(10'h000, 16);
    code_frame(10'h2a5, 16);
    code_frame(10'h2c3, 18);
    abort_frame();
    finish_test();
  end
endmodule
